/* hw/bst_defines.svh */
`ifndef BST_DEFINES_SVH
`define BST_DEFINES_SVH

// instruction register geometry and opcodes
`define BST_IR_W 2
`define BST_OP_EXTEST 2'h0
`define BST_OP_SAMPLE 2'h1
`define BST_OP_IDCODE 2'h2
`define BST_OP_BYPASS 2'h3
// fixed pattern loaded into the instruction shifter on capture
`define BST_IR_CAPTURE 2'h1

// identification register; the value is arbitrary, bit 0 must be one
`define BST_ID_W 32
`define BST_IDCODE 32'h0a5c_3001

// boundary register: input cells low, output cells high
`define BST_NPIN_IN 4
`define BST_NPIN_OUT 4
`define BST_BSR_W 8
`define BST_BSR_IN_LO 0
`define BST_BSR_OUT_LO 4

// value of the update latches after reset
`define BST_BSR_RST 8'h00

`endif

/* hw/bst_pkg.sv */
package bst_pkg;

  // four input pins of the test access port, as seen on the board
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } bst_pins_t;

  // the sixteen controller states
  typedef enum logic [3:0] {
    ST_RESET,
    ST_IDLE,
    ST_SEL_DR,
    ST_CAP_DR,
    ST_SHIFT_DR,
    ST_EXIT1_DR,
    ST_PAUSE_DR,
    ST_EXIT2_DR,
    ST_UPD_DR,
    ST_SEL_IR,
    ST_CAP_IR,
    ST_SHIFT_IR,
    ST_EXIT1_IR,
    ST_PAUSE_IR,
    ST_EXIT2_IR,
    ST_UPD_IR
  } bst_state_t;

endpackage

/* hw/bst_tap.sv */
`timescale 1ns/1ns
`include "bst_defines.svh"

// Behaviour
// - five test pins TMS TCK TDI TDO TRST; all test data follows TCK.
// - TMS and TDI are taken on each rising TCK edge.
// - TDO changes on falling TCK edges only.
// - sixteen-state controller, stepped by TCK, steered by TMS.
// - serial path runs through instruction register or selected data register.
// - four instructions: identify, bypass, sample/preload, extest.
// - test-logic reset makes identify the current instruction.
// - identify shifts out a 32-bit identification word.
// - bypass puts one shift stage between TDI and TDO.
// - sample/preload scans the boundary without disturbing pins or core.
// - sample captures pins and core signals in Capture-DR.
// - preload moves shifted data into output cell latches, not pins.
// - capture shift-out and preload shift-in share one scan pass.
// - extest drives output pins from the cell latches at once.
// - TDO is released on the first falling TCK edge with no serial shift selected.
module bst_tap (
  // system clock and reset
  input wire logic clk,
  input wire logic srst,
  // test access port
  input wire bst_pkg::bst_pins_t tap_pins,
  output logic tdo,
  output logic tdo_oe,
  // device pins and core signals under boundary scan
  input wire logic [`BST_NPIN_IN-1:0] pin_in,
  input wire logic [`BST_NPIN_OUT-1:0] core_out,
  output logic [`BST_NPIN_OUT-1:0] pin_out,
  output logic [`BST_NPIN_IN-1:0] core_in
);
  import bst_pkg::*;

  // synchroniser stages
  bst_pins_t pins_s1_r, pins_s2_r;
  logic tck_s3_r;
  logic [`BST_NPIN_IN-1:0] pin_in_s1_r, pin_in_s2_r;
  // controller and instruction
  bst_state_t st_r, st_nxt;
  logic [`BST_IR_W-1:0] ir_r, ir_sh_r;
  // data registers and update latches
  logic bypass_r;
  logic [`BST_ID_W-1:0] id_sh_r;
  logic [`BST_BSR_W-1:0] bsr_sh_r, bsr_upd_r;
  // registered outputs
  logic tdo_r, tdo_oe_r;
  logic [`BST_NPIN_OUT-1:0] pin_out_r;
  logic [`BST_NPIN_IN-1:0] core_in_r;

  // two-stage synchronisers; logic reads the second stage, and tck also its third stage
  always_ff @(posedge clk) begin
    if (srst) begin
      pins_s1_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
      pins_s2_r <= '{tck: 1'b0, tms: 1'b1, tdi: 1'b1, trst_n: 1'b0};
      tck_s3_r <= 1'b0;
      pin_in_s1_r <= '0;
      pin_in_s2_r <= '0;
    end else begin
      pins_s1_r <= tap_pins;
      pins_s2_r <= pins_s1_r;
      tck_s3_r <= pins_s2_r.tck;
      pin_in_s1_r <= pin_in;
      pin_in_s2_r <= pin_in_s1_r;
    end
  end

  // tck edges found by the system clock; tms and tdi share tck's latency
  // limitation: tck highs and lows must each last at least one clock to be seen
  wire tck_rise = pins_s2_r.tck & ~tck_s3_r;
  wire tck_fall = ~pins_s2_r.tck & tck_s3_r;
  wire tms = pins_s2_r.tms;
  wire tdi = pins_s2_r.tdi;
  // trst acts on its level, without waiting for any tck edge
  wire trst_act = ~pins_s2_r.trst_n;

  // instruction decode; width and opcodes are our own choice
  wire op_extest = (ir_r == `BST_OP_EXTEST);
  wire op_sample = (ir_r == `BST_OP_SAMPLE);
  wire op_idcode = (ir_r == `BST_OP_IDCODE);
  wire op_bypass = (ir_r == `BST_OP_BYPASS);
  wire op_bsr = op_extest | op_sample;
  // controller state decode
  wire shift_dr = (st_r == ST_SHIFT_DR);
  wire shift_ir = (st_r == ST_SHIFT_IR);
  wire cap_dr = (st_r == ST_CAP_DR);
  wire upd_dr = (st_r == ST_UPD_DR);
  wire cap_ir = (st_r == ST_CAP_IR);
  wire upd_ir = (st_r == ST_UPD_IR);
  wire in_tlr = (st_r == ST_RESET);
  // a tck rise is ignored while test reset holds the controller
  wire step = tck_rise & ~trst_act;

  // serial path selection; unknown codes cannot occur in two bits
  wire dr_bit = op_bsr ? bsr_sh_r[0] :
                op_idcode ? id_sh_r[0] : bypass_r;
  wire tdo_src = shift_ir ? ir_sh_r[0] : dr_bit;

  // controller next state, the standard sixteen-state graph
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_RESET: st_nxt = tms ? ST_RESET : ST_IDLE;
      ST_IDLE: st_nxt = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: st_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: st_nxt = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: st_nxt = tms ? ST_UPD_DR : ST_PAUSE_DR;
      ST_PAUSE_DR: st_nxt = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: st_nxt = tms ? ST_UPD_DR : ST_SHIFT_DR;
      ST_UPD_DR: st_nxt = tms ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: st_nxt = tms ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: st_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: st_nxt = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: st_nxt = tms ? ST_UPD_IR : ST_PAUSE_IR;
      ST_PAUSE_IR: st_nxt = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: st_nxt = tms ? ST_UPD_IR : ST_SHIFT_IR;
      ST_UPD_IR: st_nxt = tms ? ST_SEL_DR : ST_IDLE;
    endcase
  end

  // controller state register
  always_ff @(posedge clk) begin
    if (srst || trst_act) begin
      st_r <= ST_RESET;
    end else if (tck_rise) begin
      st_r <= st_nxt;
    end
  end

  // instruction shifter and current instruction
  always_ff @(posedge clk) begin
    if (srst || trst_act || in_tlr) begin
      ir_r <= `BST_OP_IDCODE;
      ir_sh_r <= `BST_IR_CAPTURE;
    end else if (step) begin
      if (cap_ir)
        ir_sh_r <= `BST_IR_CAPTURE;
      if (shift_ir)
        ir_sh_r <= {tdi, ir_sh_r[`BST_IR_W-1:1]};
      if (upd_ir)
        ir_r <= ir_sh_r;
    end
  end

  // bypass stage and identification shifter
  always_ff @(posedge clk) begin
    if (srst) begin
      bypass_r <= 1'b0;
      id_sh_r <= `BST_IDCODE;
    end else if (step && cap_dr) begin
      bypass_r <= 1'b0;
      id_sh_r <= `BST_IDCODE;
    end else if (step && shift_dr) begin
      bypass_r <= tdi;
      if (op_idcode)
        id_sh_r <= {tdi, id_sh_r[`BST_ID_W-1:1]};
    end
  end

  // boundary cells: capture pins and core, shift, and update latches
  always_ff @(posedge clk) begin
    if (srst) begin
      bsr_sh_r <= `BST_BSR_RST;
      bsr_upd_r <= `BST_BSR_RST;
    end else if (step && op_bsr) begin
      if (cap_dr)
        bsr_sh_r <= {core_out, pin_in_s2_r};
      if (shift_dr)
        bsr_sh_r <= {tdi, bsr_sh_r[`BST_BSR_W-1:1]};
      if (upd_dr)
        bsr_upd_r <= bsr_sh_r;
    end
  end

  // tdo and its enable move on falling tck only; released outside shifts.
  // a test reset leaves tdo driven until the next falling tck, which
  // keeps the pin from glitching between tck edges
  wire tdo_oe_nxt = ~trst_act & (shift_dr | shift_ir);
  always_ff @(posedge clk) begin
    if (srst) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tck_fall) begin
      tdo_r <= tdo_src;
      tdo_oe_r <= tdo_oe_nxt;
    end
  end

  // pins follow the core unless extest hands them to the latches;
  // the latches reset to zero, so an extest without preload drives zeros
  wire [`BST_NPIN_OUT-1:0] pin_out_nxt = op_extest ?
    bsr_upd_r[`BST_BSR_OUT_LO +: `BST_NPIN_OUT] : core_out;
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_out_r <= '0;
      core_in_r <= '0;
    end else begin
      pin_out_r <= pin_out_nxt;
      core_in_r <= pin_in_s2_r;
    end
  end

  assign tdo = tdo_r;
  assign tdo_oe = tdo_oe_r;
  assign pin_out = pin_out_r;
  assign core_in = core_in_r;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  chk_tdo_on_fall: assert property (
    $changed(tdo_r) |-> $past(tck_fall))
    else $error("tdo moved away from a falling tck edge");
  chk_tdo_release: assert property (
    tck_fall && !shift_dr && !shift_ir |=> !tdo_oe_r)
    else $error("tdo driven outside a shift state");
  chk_trst_reset: assert property (
    trst_act |=> st_r == ST_RESET ##1 ir_r == `BST_OP_IDCODE)
    else $error("trst did not reset controller and instruction");
  chk_fsm_idle: assert property (
    step && st_r == ST_RESET && !tms |=> st_r == ST_IDLE)
    else $error("reset state did not step to idle");
  chk_ir_shift_in: assert property (
    step && shift_ir |=> ir_sh_r[`BST_IR_W-1] == $past(tdi))
    else $error("instruction shifter missed tdi");
  chk_ir_update: assert property (
    step && st_r == ST_UPD_IR |=> ir_r == $past(ir_sh_r))
    else $error("instruction not updated");
  chk_bypass_path: assert property (
    tck_fall && shift_dr && op_bypass
    |=> tdo_r == $past(bypass_r))
    else $error("bypass stage not on tdo");
  chk_id_capture: assert property (
    step && st_r == ST_CAP_DR && op_idcode |=> id_sh_r == `BST_IDCODE)
    else $error("identification word not captured");
  chk_sample_cap: assert property (
    step && st_r == ST_CAP_DR && op_bsr
    |=> bsr_sh_r[`BST_BSR_IN_LO +: `BST_NPIN_IN] == $past(pin_in_s2_r))
    else $error("input cells did not capture pins");
  chk_preload_upd: assert property (
    step && st_r == ST_UPD_DR && op_sample |=> bsr_upd_r == $past(bsr_sh_r))
    else $error("preload did not reach latches");
  chk_extest_drive: assert property (
    op_extest |=> pin_out_r == $past(bsr_upd_r[`BST_BSR_OUT_LO +:
      `BST_NPIN_OUT]))
    else $error("extest pins not driven from latches");
  chk_normal_pins: assert property (
    !op_extest |=> pin_out_r == $past(core_out))
    else $error("pins disturbed outside extest");

  // tdo enable, then serial path onto tdo for instruction, identification and boundary shifters
  chk_tdo_enable: assert property (
    tck_fall && (shift_dr || shift_ir) && !trst_act |=> tdo_oe_r)
    else $error("tdo not driven in a shift state");
  chk_oe_on_fall: assert property (
    !tck_fall |=> $stable(tdo_oe_r))
    else $error("tdo enable moved away from a falling tck edge");
  chk_ir_path: assert property (
    tck_fall && shift_ir |=> tdo_r == $past(ir_sh_r[0]))
    else $error("instruction shifter not on tdo");
  chk_id_path: assert property (
    tck_fall && shift_dr && op_idcode |=> tdo_r == $past(id_sh_r[0]))
    else $error("identification word not on tdo");
  chk_bsr_path: assert property (
    tck_fall && shift_dr && op_bsr |=> tdo_r == $past(bsr_sh_r[0]))
    else $error("boundary shifter not on tdo");
  // capture and shift-in of the shifters
  chk_ir_capture: assert property (
    step && cap_ir |=> ir_sh_r == `BST_IR_CAPTURE)
    else $error("instruction shifter missed its capture value");
  chk_bypass_capture: assert property (
    step && cap_dr |=> !bypass_r)
    else $error("bypass stage not cleared on capture");
  chk_id_shift_in: assert property (
    step && shift_dr && op_idcode |=> id_sh_r[`BST_ID_W-1] == $past(tdi))
    else $error("identification shifter missed tdi");
  chk_bsr_shift_in: assert property (
    step && shift_dr && op_bsr
    |=> bsr_sh_r[`BST_BSR_W-1] == $past(tdi))
    else $error("boundary shifter missed tdi");
  chk_out_capture: assert property (
    step && cap_dr && op_bsr
    |=> bsr_sh_r[`BST_BSR_OUT_LO +: `BST_NPIN_OUT] == $past(core_out))
    else $error("output cells did not capture core");
  // controller and pin side
  chk_tlr_ident: assert property (
    in_tlr |=> ir_r == `BST_OP_IDCODE)
    else $error("test-logic reset left another instruction");
  chk_state_hold: assert property (
    !tck_rise && !trst_act |=> $stable(st_r))
    else $error("controller moved without a tck rise");
  chk_core_in_path: assert property (
    1'b1 |=> core_in_r == $past(pin_in_s2_r))
    else $error("core does not see the pins");

  cov_id_shift: cover property (step && shift_dr && op_idcode);
  cov_ir_load: cover property (step && st_r == ST_UPD_IR);
  cov_extest: cover property (op_extest && step && st_r == ST_UPD_DR);
  cov_trst: cover property (trst_act && st_r != ST_RESET);
  cov_bypass_shift: cover property (step && shift_dr && op_bypass);
endmodule

/* sim/bst_master.sv */
`timescale 1ns/1ns
// tester model: tck moves only inside frames and is parked low otherwise
module bst_master (
  // pins towards the device
  output bst_pkg::bst_pins_t pins,
  // serial return, resolved from tdo and its enable
  input wire logic tdo_pin
);
  import bst_pkg::*;
  initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
  // test reset pin, low active
  task automatic set_trst(input logic v);
    pins.trst_n = v;
  endtask
  // one tck period; tms/tdi move only at the fall, well clear of the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    pins.tms = tms;
    pins.tdi = tdi;
    #62;
    tdo = tdo_pin;
    pins.tck = 1'b1;
    #63;
    pins.tck = 1'b0;
  endtask
  // tms walk, lsb first; tdi toggles so an idle line never looks static
  task automatic walk(input logic [7:0] seq, input int n);
    logic d;
    for (int i = 0; i < n; i++) step(seq[i], ~pins.tdi, d);
  endtask
  // from idle: full scan of n bits lsb first, back to idle
  task automatic shift(input logic [31:0] din, input int n, input logic ir,
                       output logic [31:0] dout);
    dout = 32'h0;
    if (ir) walk(8'h03, 4);
    else walk(8'h01, 3);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    walk(8'h01, 2);
  endtask
  // five ones reach test-logic-reset whatever the state, then idle
  task automatic reset_tap();
    walk(8'h1f, 6);
  endtask
endmodule

/* sim/bst_tap_bench.sv */
`timescale 1ns/1ns
`include "bst_defines.svh"
module bst_tap_bench;
  import bst_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  bst_pins_t pins;
  logic tdo, tdo_oe;
  logic [3:0] pin_in = 4'h0;
  logic [3:0] core_out = 4'h0;
  logic [3:0] pin_out, core_in;
  logic [31:0] d;
  int n_errors = 0;
  int checked = 0;
  // released tdo floats, so a late enable shows up as z
  wire tdo_pin = tdo_oe ? tdo : 1'bz;

  bst_tap bst_tap_inst (.clk(clk), .srst(srst), .tap_pins(pins), .tdo(tdo),
    .tdo_oe(tdo_oe), .pin_in(pin_in), .core_out(core_out),
    .pin_out(pin_out), .core_in(core_in));
  bst_master bst_master_inst (.pins(pins), .tdo_pin(tdo_pin));

  initial forever #5 clk = ~clk;

  task automatic check(input logic [31:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // pins and core side move just after a clk rise
  task automatic set_io(input logic [3:0] pi, co);
    @(posedge clk);
    #1 pin_in = pi;
    core_out = co;
    repeat (4) @(posedge clk);
  endtask

  task automatic t_idcode();
    bst_master_inst.shift(32'h0, 32, 1'b0, d);
    check(d, `BST_IDCODE, "idcode");
    check(tdo_oe, 1'b0, "tdo released in idle");
  endtask
  task automatic t_bypass();
    bst_master_inst.shift(`BST_OP_BYPASS, 2, 1'b1, d);
    check(d, `BST_IR_CAPTURE, "ir capture");
    bst_master_inst.shift(32'h5, 4, 1'b0, d);
    check(d, 32'ha, "bypass one stage");
  endtask
  // preload 5 into output latches while sampling 6/9
  task automatic t_sample();
    set_io(4'h9, 4'h6);
    bst_master_inst.shift(`BST_OP_SAMPLE, 2, 1'b1, d);
    bst_master_inst.shift(32'h5a, 8, 1'b0, d);
    check(d, 32'h69, "sample snapshot");
    check(pin_out, 4'h6, "pins undisturbed");
    check(core_in, 4'h9, "core sees pins");
  endtask
  task automatic t_extest();
    bst_master_inst.shift(`BST_OP_EXTEST, 2, 1'b1, d);
    repeat (3) @(posedge clk);
    check(pin_out, 4'h5, "extest drives latches");
    set_io(4'h3, 4'hf);
    check(pin_out, 4'h5, "core ignored in extest");
    check(core_in, 4'h3, "core input path");
  endtask
  // test reset from extest without any tck, then identify must be back
  task automatic t_trst();
    @(posedge clk);
    #1 bst_master_inst.set_trst(1'b0);
    repeat (8) @(posedge clk);
    check(pin_out, 4'hf, "trst restores core path");
    #1 bst_master_inst.set_trst(1'b1);
    repeat (8) @(posedge clk);
    bst_master_inst.walk(8'h00, 1);
    t_idcode();
  endtask
  // tms walk to test-logic-reset also restores identify
  task automatic t_tlr();
    bst_master_inst.shift(`BST_OP_BYPASS, 2, 1'b1, d);
    bst_master_inst.reset_tap();
    t_idcode();
  endtask

  initial begin
    repeat (16) @(posedge clk);
    #1 srst = 1'b0;
    bst_master_inst.set_trst(1'b1);
    repeat (8) @(posedge clk);
    bst_master_inst.reset_tap();
    t_idcode();
    t_bypass();
    t_sample();
    t_extest();
    t_trst();
    t_tlr();
    finish_test();
  end
  // the scans above need well under 100 us
  initial begin
    #400000;
    n_errors++;
    finish_test();
  end
endmodule
